// ### core/tracker_cfg_pkg.sv
// How it works
// - Overcurrent timer from bits 7:6: 12.5ms, 50ms, 100ms, 200ms.
// - Bits 5..2 enable overcurrent monitoring on outputs 1..4.
// - First gate-delay timer from bits 7:5, 25us up to 1600ms.
// - Gate-delay bits 3..0 show live overcurrent, channels 1..4.
// - Overcurrent flag bits ignore writes; other fields stay writable.
// - Power-good code gives fraction 95, 92.5, 90 or 87.5 percent.
// - Power-good selects: channel 1 bits 1:0 up to channel 4 bits 7:6.
`default_nettype none
package tracker_cfg_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_OC_CTRL = 8'h0e;
    localparam logic [7:0] ADDR_GATE_DELAY = 8'h0f;
    localparam logic [7:0] ADDR_PG_THRESH = 8'h10;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // Writable masks; unused bits read as zero
    localparam logic [7:0] OC_CTRL_WMASK = 8'hfc;
    localparam logic [7:0] GATE_DELAY_WMASK = 8'he0;
    localparam int OC_TIMER_LSB = 6;
    localparam int OC_EN_MSB = 5;
    localparam int GATE_DELAY_LSB = 5;
    localparam int CH = 4;
    // ------------------------------------------------------------
    // Timing, in tenths of a millisecond (microseconds where needed)
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    // Timer durations in units of 0.1 ms, except the 25 us entry
    localparam int T_25US_US = 25;
    localparam int T_12P5_MS_X10 = 125;
    localparam int T_50_MS_X10 = 500;
    localparam int T_100_MS_X10 = 1000;
    localparam int T_200_MS_X10 = 2000;
    localparam int T_25_MS_X10 = 250;
    localparam int T_400_MS_X10 = 4000;
    localparam int T_1600_MS_X10 = 16000;
    // Power-good fraction, tenths of a percent
    localparam logic [9:0] PG_950 = 10'd950;
    localparam logic [9:0] PG_925 = 10'd925;
    localparam logic [9:0] PG_900 = 10'd900;
    localparam logic [9:0] PG_875 = 10'd875;
endpackage
`default_nettype wire

// ### core/tracker_cfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tracker_cfg_regs
    import tracker_cfg_pkg::*;
(
    input wire logic mclk, // 200 MHz clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [7:0] reg_addr, // Register address
    input wire logic reg_wr, // Write strobe
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, registered
    input wire logic [CH-1:0] overcurrent_flag, // Live, index 0 = ch 1
    output logic [31:0] oc_timer_cycles, // Overcurrent timer length
    output logic [CH-1:0] oc_monitor_en, // Index 0 = output 1
    output logic [31:0] first_gate_delay_cycles, // Gate-delay length
    output logic [CH*10-1:0] pg_fraction // Per channel, 0.1 %
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] oc_ctrl;
        logic [7:0] gate_delay;
        logic [7:0] pg_thresh;
        logic [7:0] rdata;
    } state_t;
    state_t st, next_st;

    localparam logic [31:0] CYC_PER_01MS = 32'(CLK_MHZ * 100);

    always_comb begin
        next_st = st;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_OC_CTRL: next_st.oc_ctrl = reg_wdata & OC_CTRL_WMASK;
                // Flag bits are never stored, so writes cannot touch them
                ADDR_GATE_DELAY: begin
                    next_st.gate_delay = reg_wdata & GATE_DELAY_WMASK;
                end
                ADDR_PG_THRESH: next_st.pg_thresh = reg_wdata;
                default: ;
            endcase
        end
        case (reg_addr)
            ADDR_OC_CTRL: next_st.rdata = st.oc_ctrl;
            // Live flags: bit 3 is channel 1, bit 0 channel 4
            ADDR_GATE_DELAY: begin
                next_st.rdata = st.gate_delay | {4'h0, overcurrent_flag[0],
                    overcurrent_flag[1], overcurrent_flag[2],
                    overcurrent_flag[3]};
            end
            ADDR_PG_THRESH: next_st.rdata = st.pg_thresh;
            default: next_st.rdata = RESET_VALUE;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    always_comb begin
        case (st.oc_ctrl[OC_TIMER_LSB+:2])
            2'h0: oc_timer_cycles = T_12P5_MS_X10 * CYC_PER_01MS;
            2'h1: oc_timer_cycles = T_50_MS_X10 * CYC_PER_01MS;
            2'h2: oc_timer_cycles = T_100_MS_X10 * CYC_PER_01MS;
            default: oc_timer_cycles = T_200_MS_X10 * CYC_PER_01MS;
        endcase
    end

    always_comb begin
        case (st.gate_delay[GATE_DELAY_LSB+:3])
            3'h0: first_gate_delay_cycles = 32'(T_25US_US * CLK_MHZ);
            3'h1: first_gate_delay_cycles = T_12P5_MS_X10 * CYC_PER_01MS;
            3'h2: first_gate_delay_cycles = T_25_MS_X10 * CYC_PER_01MS;
            3'h3: first_gate_delay_cycles = T_50_MS_X10 * CYC_PER_01MS;
            3'h4: first_gate_delay_cycles = T_100_MS_X10 * CYC_PER_01MS;
            3'h5: first_gate_delay_cycles = T_200_MS_X10 * CYC_PER_01MS;
            3'h6: first_gate_delay_cycles =
                T_400_MS_X10 * CYC_PER_01MS;
            default: first_gate_delay_cycles =
                T_1600_MS_X10 * CYC_PER_01MS;
        endcase
    end

    genvar i;
    generate
        for (i = 0; i < CH; i++) begin : g_ch
            // Output 1 sits in bit 5, output 4 in bit 2
            assign oc_monitor_en[i] = st.oc_ctrl[OC_EN_MSB-i];
            always_comb begin
                case (st.pg_thresh[2*i+:2])
                    2'h0: pg_fraction[10*i+:10] = PG_950;
                    2'h1: pg_fraction[10*i+:10] = PG_925;
                    2'h2: pg_fraction[10*i+:10] = PG_900;
                    default: pg_fraction[10*i+:10] = PG_875;
                endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_flag_readback;
        @(posedge mclk) disable iff (!reset_n)
        reg_addr == ADDR_GATE_DELAY |=> reg_rdata[3:0] ==
            {$past(overcurrent_flag[0]), $past(overcurrent_flag[1]),
             $past(overcurrent_flag[2]), $past(overcurrent_flag[3])};
    endproperty
    a_flag_readback: assert property (p_flag_readback)
        else $error("overcurrent flag readback wrong");

    property p_flag_write_ignored;
        @(posedge mclk) disable iff (!reset_n)
        reg_wr && reg_addr == ADDR_GATE_DELAY |=>
            st.gate_delay[3:0] == 4'h0 &&
            st.gate_delay[7:5] == $past(reg_wdata[7:5]);
    endproperty
    a_flag_write_ignored: assert property (p_flag_write_ignored)
        else $error("gate-delay write handled wrongly");

    property p_oc_timer;
        @(posedge mclk) disable iff (!reset_n)
        st.oc_ctrl[7:6] == 2'h0 |-> oc_timer_cycles == 32'd2500000;
    endproperty
    a_oc_timer: assert property (p_oc_timer)
        else $error("overcurrent timer decode wrong");

    property p_oc_enable;
        @(posedge mclk) disable iff (!reset_n)
        reg_wr && reg_addr == ADDR_OC_CTRL |=>
            oc_monitor_en == {$past(reg_wdata[2]), $past(reg_wdata[3]),
                              $past(reg_wdata[4]), $past(reg_wdata[5])};
    endproperty
    a_oc_enable: assert property (p_oc_enable)
        else $error("overcurrent enable mapping wrong");

    property p_gate_short;
        @(posedge mclk) disable iff (!reset_n)
        st.gate_delay[7:5] == 3'h0 |-> first_gate_delay_cycles == 32'd5000;
    endproperty
    a_gate_short: assert property (p_gate_short)
        else $error("gate delay 25us decode wrong");

    property p_gate_110;
        @(posedge mclk) disable iff (!reset_n)
        st.gate_delay[7:5] == 3'h6 |-> first_gate_delay_cycles == 32'd80000000;
    endproperty
    a_gate_110: assert property (p_gate_110)
        else $error("gate delay code 110 wrong");

    property p_pg_ch4;
        @(posedge mclk) disable iff (!reset_n)
        reg_wr && reg_addr == ADDR_PG_THRESH && reg_wdata[7:6] == 2'h3 |=>
            pg_fraction[39:30] == 10'd875;
    endproperty
    a_pg_ch4: assert property (p_pg_ch4)
        else $error("channel 4 threshold placement wrong");

    property p_pg_ch1;
        @(posedge mclk) disable iff (!reset_n)
        st.pg_thresh[1:0] == 2'h1 |-> pg_fraction[9:0] == 10'd925;
    endproperty
    a_pg_ch1: assert property (p_pg_ch1)
        else $error("power-good fraction decode wrong");

    property p_oc_timer_50;
        @(posedge mclk) disable iff (!reset_n)
        st.oc_ctrl[7:6] == 2'h1 |-> oc_timer_cycles == 32'd10000000;
    endproperty
    a_oc_timer_50: assert property (p_oc_timer_50)
        else $error("overcurrent timer 50ms decode wrong");

    property p_oc_timer_200;
        @(posedge mclk) disable iff (!reset_n)
        st.oc_ctrl[7:6] == 2'h3 |-> oc_timer_cycles == 32'd40000000;
    endproperty
    a_oc_timer_200: assert property (p_oc_timer_200)
        else $error("overcurrent timer 200ms decode wrong");

    // Unused low bits must store as zero so they never read back set
    property p_oc_ctrl_store;
        @(posedge mclk) disable iff (!reset_n)
        reg_wr && reg_addr == ADDR_OC_CTRL |=>
            st.oc_ctrl[7:2] == $past(reg_wdata[7:2]) &&
            st.oc_ctrl[1:0] == 2'h0;
    endproperty
    a_oc_ctrl_store: assert property (p_oc_ctrl_store)
        else $error("overcurrent control write stored wrongly");

    property p_gate_field_read;
        @(posedge mclk) disable iff (!reset_n)
        reg_addr == ADDR_GATE_DELAY |=>
            reg_rdata[7:5] == $past(st.gate_delay[7:5]) && !reg_rdata[4];
    endproperty
    a_gate_field_read: assert property (p_gate_field_read)
        else $error("gate-delay field readback wrong");

    property p_gate_12p5;
        @(posedge mclk) disable iff (!reset_n)
        st.gate_delay[7:5] == 3'h1 |->
            first_gate_delay_cycles == 32'd2500000;
    endproperty
    a_gate_12p5: assert property (p_gate_12p5)
        else $error("gate delay 12.5ms decode wrong");

    property p_gate_111;
        @(posedge mclk) disable iff (!reset_n)
        st.gate_delay[7:5] == 3'h7 |->
            first_gate_delay_cycles == 32'd320000000;
    endproperty
    a_gate_111: assert property (p_gate_111)
        else $error("gate delay code 111 wrong");

    property p_pg_store;
        @(posedge mclk) disable iff (!reset_n)
        reg_wr && reg_addr == ADDR_PG_THRESH |=>
            st.pg_thresh == $past(reg_wdata);
    endproperty
    a_pg_store: assert property (p_pg_store)
        else $error("power-good threshold byte stored wrongly");

    property p_pg_ch2;
        @(posedge mclk) disable iff (!reset_n)
        st.pg_thresh[3:2] == 2'h2 |-> pg_fraction[19:10] == 10'd900;
    endproperty
    a_pg_ch2: assert property (p_pg_ch2)
        else $error("channel 2 power-good decode wrong");
endmodule
`default_nettype wire

// ### sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic mclk, // Bus clock
    input wire logic [7:0] reg_rdata, // Read data from device
    output logic [7:0] reg_addr, // Register address
    output logic reg_wr, // Write strobe
    output logic [7:0] reg_wdata // Write data
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // Data inverted after a write so a stale byte is never mistaken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        @(negedge mclk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ### sim/supply_tracker_oc_pg_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module supply_tracker_oc_pg_config_regs_tb_top;
    import tracker_cfg_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, wd;
    logic reg_wr;
    logic [3:0] overcurrent_flag = 4'h0;
    logic [3:0] oc_monitor_en, f;
    logic [31:0] oc_timer_cycles, first_gate_delay_cycles;
    logic [39:0] pg_fraction;
    int failures = 0;
    int total_checks = 0;
    int oc_us[4] = '{12500, 50000, 100000, 200000};
    int gd_us[8] = '{25, 12500, 25000, 50000, 100000, 200000, 400000,
        1600000};
    logic [9:0] pg[4] = '{10'd950, 10'd925, 10'd900, 10'd875};
    tracker_cfg_regs tracker_cfg_regs_inst (.mclk(mclk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .overcurrent_flag(overcurrent_flag),
        .oc_timer_cycles(oc_timer_cycles), .oc_monitor_en(oc_monitor_en),
        .first_gate_delay_cycles(first_gate_delay_cycles),
        .pg_fraction(pg_fraction));
    host_model host_model_inst (.mclk(mclk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_oc;
        for (int c = 0; c < 4; c++) begin
            wd = {c[1:0], 4'h8 >> c, 2'b11};
            host_model_inst.wr(ADDR_OC_CTRL, wd);
            chk(oc_timer_cycles, oc_us[c] * 200);
            chk(oc_monitor_en, 4'h1 << c);
            host_model_inst.rd(ADDR_OC_CTRL, rv);
            chk(rv, wd & 8'hfc);
        end
    endtask
    task automatic t_gd;
        for (int c = 0; c < 8; c++) begin
            f = 4'(c * 5 + 1);
            overcurrent_flag = f;
            host_model_inst.wr(ADDR_GATE_DELAY, {c[2:0], 5'h1f});
            chk(first_gate_delay_cycles, gd_us[c] * 200);
            host_model_inst.rd(ADDR_GATE_DELAY, rv);
            chk(rv, {c[2:0], 1'b0, f[0], f[1], f[2], f[3]});
        end
    endtask
    task automatic t_pg;
        for (int c = 0; c < 4; c++) begin
            wd = {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)};
            host_model_inst.wr(ADDR_PG_THRESH, wd);
            chk(pg_fraction, {pg[(c + 3) % 4], pg[(c + 2) % 4],
                pg[(c + 1) % 4], pg[c]});
            host_model_inst.rd(ADDR_PG_THRESH, rv);
            chk(rv, wd);
        end
    endtask
    // Unmapped write must leave the last threshold byte untouched
    task automatic t_unmapped;
        host_model_inst.wr(8'h11, 8'hff);
        host_model_inst.rd(8'h11, rv);
        chk(rv, 8'h00);
        host_model_inst.rd(ADDR_PG_THRESH, rv);
        chk(rv, 8'h93);
    endtask
    // Cleared registers decode to each field's code-zero value
    task automatic t_reset_values;
        chk(oc_timer_cycles, 32'd2500000);
        chk(oc_monitor_en, 4'h0);
        chk(first_gate_delay_cycles, 32'd5000);
        chk(pg_fraction, {4{10'd950}});
        host_model_inst.rd(ADDR_OC_CTRL, rv);
        chk(rv, 8'h00);
        host_model_inst.rd(ADDR_PG_THRESH, rv);
        chk(rv, 8'h00);
    endtask
    // Reset dropped between edges must clear the overcurrent and power-good fields before a clock
    task automatic t_reset_mid;
        host_model_inst.wr(ADDR_OC_CTRL, 8'hfc);
        host_model_inst.wr(ADDR_PG_THRESH, 8'hff);
        chk(oc_monitor_en, 4'hf);
        chk(pg_fraction, {4{10'd875}});
        @(negedge mclk);
        reset_n = 1'b0;
        #1;
        chk(oc_timer_cycles, 32'd2500000);
        chk(oc_monitor_en, 4'h0);
        chk(pg_fraction, {4{10'd950}});
        @(negedge mclk);
        reset_n = 1'b1;
        t_reset_values();
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        t_reset_values();
        t_oc();
        t_gd();
        t_pg();
        t_unmapped();
        t_reset_mid();
        tally_and_finish();
    end
    initial begin
        #10000;
        failures++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
